//--- lfs_ext.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// far side: pull-up on the shared fault line
module lfs_ext (
  // open-drain driver from the device
  input wire logic i_fault_o,
  input wire logic i_fault_oe_n,
  // resolved pin level
  output logic o_fault_pin
);
  // released line floats up to the pull-up level
  assign o_fault_pin = i_fault_oe_n ? 1'b1 : i_fault_o;
endmodule
`default_nettype wire

//--- lfs_pkg.sv
package lfs_pkg;
  // clock
  localparam int CLK_PERIOD_NS = 10;
  // qualification times
  localparam int QUAL_TIME_US = 1200;
  localparam int SHDN_TIME_MS = 200;
  localparam int QUAL_CYCLES = QUAL_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int SHDN_CYCLES = SHDN_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int CNT_W = 25;
  // fault source index
  localparam int FLT_SHORT = 0;
  localparam int FLT_OPEN = 1;
  localparam int FLT_OVP = 2;
  localparam int NUM_FLT = 3;
  // power state
  typedef enum logic [1:0] {LFS_RUN, LFS_SHDN} lfs_pwr_t;
endpackage

//--- lfs_qual.sv
`timescale 1ns/10ps
`default_nettype none
// continuous-condition qualification timer
module lfs_qual #(
  parameter int LIMIT = 4
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // condition and result
  input wire logic i_cond,
  output logic o_qual
);
  import lfs_pkg::*;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  localparam logic [CNT_W-1:0] LIM = CNT_W'(LIMIT);
  // count while condition holds, restart on break
  assign cnt_next = !i_cond ? '0 : (cnt_reg == LIM) ? cnt_reg : cnt_reg + 1'b1;
  // =====================================
  // counter
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      cnt_reg <= '0;
    else
      cnt_reg <= cnt_next;
  end
  // qualified once held longer than limit
  assign o_qual = i_cond && (cnt_reg == LIM);
  AST_RESTART: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    !i_cond |=> cnt_reg == '0) else $error("timer not restarted");
endmodule
`default_nettype wire

//--- lfs_sync.sv
`timescale 1ns/10ps
`default_nettype none
// two flip-flop synchroniser
module lfs_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // data
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] q_reg;
  // =====================================
  // double flop
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      meta_reg <= '0;
      q_reg <= '0;
    end
    else
    begin
      meta_reg <= i_d;
      q_reg <= meta_reg;
    end
  end
  assign o_q = q_reg;
endmodule
`default_nettype wire

//--- lfs_top.sv
`timescale 1ns/10ps
`default_nettype none
// led driver fault supervisor
module lfs_top #(
  parameter int QUAL_LIMIT = lfs_pkg::QUAL_CYCLES,
  parameter int SHDN_LIMIT = lfs_pkg::SHDN_CYCLES
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // comparator and control inputs, asynchronous
  input wire logic i_pwm_dim_input,
  input wire logic i_short_cmp,
  input wire logic i_open_cmp,
  input wire logic i_ref_above_cmp,
  input wire logic i_ovp_fb_cmp,
  input wire logic i_overvoltage_protect,
  input wire logic i_over_temp,
  input wire logic i_ton_high_req,
  input wire logic i_ton_low_req,
  // gate drivers
  output logic o_high_side_gate,
  output logic o_low_side_gate,
  // open-drain fault pin
  output logic o_fault_out_n_o,
  output logic o_fault_out_n_oe_n,
  // regulator and current monitor
  output logic o_regulated_5v_output_en,
  output logic o_sample_switch_close,
  output logic o_monitor_hold
);
  import lfs_pkg::*;
  localparam int NIN = 9;
  logic [NIN-1:0] raw;
  logic [NIN-1:0] syn;
  logic pwm_dim_input, sh, op, refok, fb, overvoltage_protect, ot, thi, tlo;
  logic [NUM_FLT-1:0] cond;
  logic [NUM_FLT-1:0] qual;
  logic [NUM_FLT-1:0] rep_reg;
  logic [NUM_FLT-1:0] rep_next;
  lfs_pwr_t pwr_reg;
  lfs_pwr_t pwr_next;
  logic shdn_qual;
  logic ovp_block_reg;
  logic ovp_block_next;
  logic gate_ok;
  logic hs_reg;
  logic ls_reg;
  logic flt_reg;
  logic flt_next;
  logic hold_reg;
  logic dim_d_reg;
  logic dim_fall;
  // =====================================
  // input synchronisation
  assign raw = {i_ton_low_req, i_ton_high_req, i_over_temp, i_overvoltage_protect,
                i_ovp_fb_cmp, i_ref_above_cmp, i_open_cmp, i_short_cmp, i_pwm_dim_input};
  lfs_sync #(.W(NIN)) u_sync (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_d(raw),
    .o_q(syn)
  );
  assign {tlo, thi, ot, overvoltage_protect, fb, refok, op, sh, pwm_dim_input} = syn;
  // =====================================
  // fault qualification
  assign cond[FLT_SHORT] = sh;
  assign cond[FLT_OPEN] = op && refok;
  assign cond[FLT_OVP] = fb;
  genvar g;
  generate
    for (g = 0; g < NUM_FLT; g++)
    begin : g_qual
      lfs_qual #(.LIMIT(QUAL_LIMIT)) u_qual (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .i_cond(cond[g]),
        .o_qual(qual[g])
      );
      // report starts only while dim high, then holds until condition clears
      assign rep_next[g] = qual[g] && (pwm_dim_input || rep_reg[g]);
    end
  endgenerate
  // =====================================
  // shutdown timer on dim low
  lfs_qual #(.LIMIT(SHDN_LIMIT)) u_shdn (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_cond(!pwm_dim_input),
    .o_qual(shdn_qual)
  );
  assign pwr_next = pwm_dim_input ? LFS_RUN : (shdn_qual ? LFS_SHDN : pwr_reg);
  // =====================================
  // overvoltage trip, block register follows the trip one cycle late
  assign ovp_block_next = overvoltage_protect ? 1'b1 : (ovp_block_reg ? overvoltage_protect : 1'b0);
  // drivers allowed only with dim high and no trip
  assign gate_ok = pwm_dim_input && !overvoltage_protect && !ovp_block_reg && !ot && (pwr_reg == LFS_RUN);
  // fault output: reported faults, thermal, shutdown
  assign flt_next = (|rep_next) || ot || (pwr_next == LFS_SHDN);
  assign dim_fall = dim_d_reg && !pwm_dim_input;
  // =====================================
  // state registers
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rep_reg <= '0;
      pwr_reg <= LFS_RUN;
      ovp_block_reg <= 1'b0;
      flt_reg <= 1'b0;
      dim_d_reg <= 1'b0;
    end
    else
    begin
      rep_reg <= rep_next;
      pwr_reg <= pwr_next;
      ovp_block_reg <= ovp_block_next;
      flt_reg <= flt_next;
      dim_d_reg <= pwm_dim_input;
    end
  end
  // =====================================
  // gate drive, non-overlapping
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      hs_reg <= 1'b0;
      ls_reg <= 1'b0;
    end
    else
    begin
      hs_reg <= gate_ok && thi && !tlo && !ls_reg;
      ls_reg <= gate_ok && tlo && !thi && !hs_reg;
    end
  end
  // =====================================
  // current monitor hold on dim fall
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      hold_reg <= 1'b0;
    else if (dim_fall)
      hold_reg <= 1'b1;
    else if (pwm_dim_input)
      hold_reg <= 1'b0;
  end
  // =====================================
  // outputs
  assign o_high_side_gate = hs_reg;
  assign o_low_side_gate = ls_reg;
  assign o_sample_switch_close = ls_reg && !hold_reg && !dim_fall;
  assign o_monitor_hold = hold_reg;
  assign o_fault_out_n_o = 1'b0;
  assign o_fault_out_n_oe_n = !flt_reg;
  assign o_regulated_5v_output_en = (pwr_reg == LFS_RUN);
  // =====================================
  // checks
  AST_OVP_GATES: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    overvoltage_protect |=> !o_high_side_gate && !o_low_side_gate) else $error("gates on during ovp");
  AST_HYST: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    ovp_block_reg && overvoltage_protect |=> !o_high_side_gate) else $error("released before hysteresis");
  AST_OT_GATES: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    ot |=> !o_high_side_gate && !o_low_side_gate) else $error("gates on while hot");
  AST_OT_FLT: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    ot |=> !o_fault_out_n_oe_n) else $error("thermal fault missing");
  AST_DIM_GATES: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    !pwm_dim_input |=> !o_high_side_gate && !o_low_side_gate) else $error("gates on with dim low");
  AST_SHDN_FLT: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    pwr_reg == LFS_SHDN |-> !o_fault_out_n_oe_n && !o_regulated_5v_output_en)
    else $error("shutdown outputs wrong");
  AST_REPORT_DIM: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    $rose(rep_reg[FLT_SHORT]) |-> $past(pwm_dim_input)) else $error("short reported dim low");
  AST_HOLD: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    rep_reg[FLT_OVP] && qual[FLT_OVP] |=> rep_reg[FLT_OVP]) else $error("ovp report dropped");
  AST_OPEN_REF: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    !refok |=> !qual[FLT_OPEN]) else $error("open qualified low ref");
  AST_SAMPLE: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    !o_low_side_gate |-> !o_sample_switch_close) else $error("sample with gate low");
  AST_FLT_OD: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    !o_fault_out_n_o) else $error("fault pin drives high");
  // =====================================
  // per fault report checks
  genvar h;
  generate
    for (h = 0; h < NUM_FLT; h++)
    begin : g_chk
      // a report needs a qualified fault behind it
      AST_REP_NEEDS_QUAL: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        rep_reg[h]
        |-> $past(qual[h]))
        else $error("report without qualified fault");

      // a report only starts with dim high
      AST_REP_START_DIM: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        $rose(rep_reg[h])
        |-> $past(pwm_dim_input))
        else $error("report started with dim low");

      // report drops once the condition is gone
      AST_REP_DROP: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        !qual[h]
        |=> !rep_reg[h])
        else $error("report outlived its fault");

      // report stays while the fault stays
      AST_REP_KEEP: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        rep_reg[h] && qual[h]
        |=> rep_reg[h])
        else $error("report dropped early");

      // qualified fault with dim high is reported
      AST_REP_RAISE: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        qual[h] && pwm_dim_input
        |=> rep_reg[h])
        else $error("qualified fault not reported");

      // every report pulls the pin low
      AST_REP_FLT: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        rep_reg[h]
        |-> !o_fault_out_n_oe_n)
        else $error("report not on fault pin");

      // no qualification without the condition
      AST_COND_QUAL: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        !cond[h]
        |-> !qual[h])
        else $error("qualified without condition");
    end
  endgenerate
  // =====================================
  // gate, power, fault pin, monitor and open reference checks
  // never both gates on
  AST_NO_OVERLAP: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    !(o_high_side_gate && o_low_side_gate))
    else $error("both gates on");

  // high gate only on a high request
  AST_HS_NEEDS_REQ: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    o_high_side_gate
    |-> $past(thi))
    else $error("high gate without request");

  // low gate only on a low request
  AST_LS_NEEDS_REQ: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    o_low_side_gate
    |-> $past(tlo))
    else $error("low gate without request");

  // allowed high request turns the high gate on
  AST_HS_ON: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    gate_ok && thi && !tlo && !ls_reg
    |=> o_high_side_gate)
    else $error("high gate missing");

  // allowed low request turns the low gate on
  AST_LS_ON: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    gate_ok && tlo && !thi && !hs_reg
    |=> o_low_side_gate)
    else $error("low gate missing");

  // any gate on needs switching allowed
  AST_GATE_NEEDS_OK: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    o_high_side_gate || o_low_side_gate
    |-> $past(gate_ok))
    else $error("gate on while blocked");

  // shutdown keeps both gates off
  AST_SHDN_GATES: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    pwr_reg == LFS_SHDN
    |=> !o_high_side_gate && !o_low_side_gate)
    else $error("gates on in shutdown");

  // trip still held blocks the high gate
  AST_BLOCK_GATES: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    ovp_block_reg
    |=> !o_high_side_gate)
    else $error("resumed during trip");

  // dim high keeps the regulator on
  AST_REG_ON: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    pwm_dim_input
    |=> o_regulated_5v_output_en)
    else $error("regulator off with dim high");

  // long dim low enters shutdown
  AST_SHDN_ENTRY: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    !pwm_dim_input && shdn_qual
    |=> pwr_reg == LFS_SHDN)
    else $error("shutdown not entered");

  // no shutdown before the timer expires
  AST_SHDN_EARLY: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    !shdn_qual && pwr_reg == LFS_RUN
    |=> pwr_reg == LFS_RUN)
    else $error("shutdown too early");

  // dim high leaves shutdown
  AST_SHDN_EXIT: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    pwr_reg == LFS_SHDN && pwm_dim_input
    |=> pwr_reg == LFS_RUN)
    else $error("shutdown not left");

  // pin released when no cause stands
  AST_FLT_QUIET: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    !flt_next
    |=> o_fault_out_n_oe_n)
    else $error("fault pin low without cause");

  // pin low only with a cause
  AST_FLT_CAUSE: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    !o_fault_out_n_oe_n
    |-> $past(flt_next))
    else $error("fault pin low unexplained");

  // dim fall starts the monitor hold
  AST_MON_HOLD: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    dim_fall
    |=> o_monitor_hold)
    else $error("monitor hold missing");

  // holding keeps the sample switch open
  AST_HOLD_SAMPLE: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    o_monitor_hold
    |-> !o_sample_switch_close)
    else $error("sampling while holding");

  // dim high ends the hold
  AST_HOLD_RELEASE: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    pwm_dim_input
    |=> !o_monitor_hold)
    else $error("hold kept with dim high");

  // low gate samples when not holding
  AST_SAMPLE_ON: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    o_low_side_gate && !o_monitor_hold && !dim_fall
    |-> o_sample_switch_close)
    else $error("sample switch not closed");

  // open fault needs the reference above limit
  AST_OPEN_QUAL_REF: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    qual[FLT_OPEN]
    |-> refok)
    else $error("open qualified without reference");
endmodule
`default_nettype wire

//--- lfs_top_tb.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// bench for the fault supervisor
module lfs_top_tb;
  import lfs_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic pwm_dim_input = 1'b0, sc = 1'b0, oc = 1'b0, rf = 1'b0, ofb = 1'b0;
  logic overvoltage_protect = 1'b0, ot = 1'b0, th = 1'b0, tl = 1'b0;
  logic hs, ls, f_o, f_oe_n, reg_en, smp, hold, pin;
  int failures = 0;
  int n_tests = 0;
  // 100 MHz clock
  always #5 clk = ~clk;
  lfs_top #(.QUAL_LIMIT(8), .SHDN_LIMIT(100)) u_dut (
    .i_mclk(clk), .i_rst_n(rst_n), .i_pwm_dim_input(pwm_dim_input), .i_short_cmp(sc),
    .i_open_cmp(oc), .i_ref_above_cmp(rf), .i_ovp_fb_cmp(ofb),
    .i_overvoltage_protect(overvoltage_protect), .i_over_temp(ot), .i_ton_high_req(th),
    .i_ton_low_req(tl), .o_high_side_gate(hs), .o_low_side_gate(ls),
    .o_fault_out_n_o(f_o), .o_fault_out_n_oe_n(f_oe_n),
    .o_regulated_5v_output_en(reg_en), .o_sample_switch_close(smp),
    .o_monitor_hold(hold));
  lfs_ext u_ext (.i_fault_o(f_o), .i_fault_oe_n(f_oe_n), .o_fault_pin(pin));
  // ==========================================
  // helpers
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic seen, input logic exp, input string what);
    n_tests++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask
  task automatic setc(input int k, input logic v);
    @(posedge clk);
    case (k)
      0: sc <= v;
      1: oc <= v;
      default: ofb <= v;
    endcase
  endtask
  task automatic conclude;
    $display("checks %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // watchdog on a hung run
  initial
  begin
    #20000;
    failures++;
    conclude();
  end
  // ==========================================
  // test sequence
  initial
  begin
    cyc(10);
    chk(hs, 1'b0, "gate in reset");
    chk(pin, 1'b1, "fault in reset");
    @(posedge clk) rst_n <= 1'b1;
    @(posedge clk) pwm_dim_input <= 1'b1;
    @(posedge clk) th <= 1'b1;
    cyc(5);
    chk(hs, 1'b1, "high gate on");
    @(posedge clk) th <= 1'b0;
    @(posedge clk) tl <= 1'b1;
    cyc(5);
    chk(ls, 1'b1, "low gate on");
    chk(smp, 1'b1, "sample closed");
    @(posedge clk) tl <= 1'b0;
    @(posedge clk) th <= 1'b1;
    cyc(5);
    chk(smp, 1'b0, "sample open");
    @(posedge clk) overvoltage_protect <= 1'b1;
    cyc(5);
    chk(hs, 1'b0, "ovp gate");
    chk(pin, 1'b1, "ovp no report");
    @(posedge clk) overvoltage_protect <= 1'b0;
    cyc(5);
    chk(hs, 1'b1, "ovp resume");
    @(posedge clk) ot <= 1'b1;
    cyc(4);
    chk(hs, 1'b0, "thermal gate");
    chk(pin, 1'b0, "thermal fault");
    @(posedge clk) ot <= 1'b0;
    @(posedge clk) rf <= 1'b1;
    for (int k = 0; k < NUM_FLT; k++)
    begin
      setc(k, 1'b1);
      cyc(6);
      chk(pin, 1'b1, "early fault");
      cyc(14);
      chk(pin, 1'b0, "fault qualified");
      @(posedge clk) pwm_dim_input <= 1'b0;
      cyc(5);
      chk(pin, 1'b0, "fault held");
      setc(k, 1'b0);
      cyc(5);
      chk(pin, 1'b1, "fault gone");
      @(posedge clk) pwm_dim_input <= 1'b1;
    end
    setc(0, 1'b1);
    cyc(8);
    setc(0, 1'b0);
    setc(0, 1'b1);
    cyc(6);
    chk(pin, 1'b1, "timer restart");
    @(posedge clk) pwm_dim_input <= 1'b0;
    cyc(30);
    chk(pin, 1'b1, "dim low gating");
    chk(hs, 1'b0, "dim low gate");
    setc(0, 1'b0);
    @(posedge clk) pwm_dim_input <= 1'b1;
    @(posedge clk) rf <= 1'b0;
    setc(1, 1'b1);
    cyc(30);
    chk(pin, 1'b1, "open needs ref");
    setc(1, 1'b0);
    @(posedge clk) pwm_dim_input <= 1'b0;
    cyc(4);
    chk(hold, 1'b1, "monitor hold");
    cyc(110);
    chk(reg_en, 1'b0, "regulator off");
    chk(pin, 1'b0, "shutdown fault");
    @(posedge clk) pwm_dim_input <= 1'b1;
    cyc(5);
    chk(reg_en, 1'b1, "regulator back");
    conclude();
  end
endmodule
`default_nettype wire
